// [design/vmc_defines.vh]
// Register map, field positions, reset values and timing counts for the
// miscellaneous control group. Definitions only; included by bare name.
`ifndef VMC_DEFINES_VH
`define VMC_DEFINES_VH

`define VMC_OFF_CTL          12'h404
`define VMC_OFF_STAT         12'h408
`define VMC_OFF_UAM          12'h40c

`define VMC_BTO_LSB          28
`define VMC_ARB_MODE_BIT     26
`define VMC_ARBTO_LSB        24
`define VMC_LOCAL_RESET_OUT_BIT         23
`define VMC_BRST_BIT         22
`define VMC_ISO_BIT          20
`define VMC_GISO_BIT         19
`define VMC_LEGACY_BIT       18
`define VMC_SYSTEM_CONTROLLER_FLAG_BIT       17
`define VMC_AUTOID_BIT       16
`define VMC_SYSRST_BIT       14

`define VMC_PCIW_BIT         30
`define VMC_ALTEN_BIT        27
`define VMC_BBSY_BIT         22
`define VMC_ALTDONE_BIT      19
`define VMC_TARGET_POST_FIFO_EMPTY_BIT         18
`define VMC_SLAVE_POST_FIFO_EMPTY_BIT         17
`define VMC_ALTID_LSB        8

`define VMC_UAM_A_LSB        26
`define VMC_UAM_B_LSB        18
`define VMC_UAM_PREFIX       2'h1

`define VMC_BTO_RST          4'h3
`define VMC_ARBTO_RST        2'h1
`define VMC_UAM_RST          4'h0

`define VMC_CLK_MHZ          50
`define VMC_TICK_US          4
// One 4 us tick is 200 cycles of the 50 MHz clock, sized for the prescaler.
`define VMC_TICK_CYC         8'hc8
`define VMC_ARB_MIN_US       8
`define VMC_PULSE_CYC        8'h10

`endif

// [design/vmc_misc_regs.v]
// Miscellaneous control, status and user_address_modifier_codes code registers of the bridge,
// with the backplane bus timer, arbitration timer and auto-ID sequencer.
// Assumes a simple register port on clk (one-cycle rd/wr strobes, byte
// address); bus and FIFO status lines arrive from other clock domains.
`timescale 1ns/10ps
`default_nettype none
`include "vmc_defines.vh"

module vmc_misc_regs (
    input  wire        clk,
    input  wire        reset,
    input  wire        clk_en,
    input  wire [11:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [31:0] reg_wdata,
    input  wire        wr_from_pci,
    output reg  [31:0] reg_rdata_ff,
    input  wire        strap_isolation,
    input  wire        strap_system_controller_flag,
    input  wire        strap_auto_id,
    input  wire        strap_alt_auto_id,
    input  wire        pci_rst_n,
    input  wire        req64_n,
    input  wire        own_bbsy_n,
    input  wire        target_fifo_empty,
    input  wire        slave_fifo_empty,
    input  wire        irq_level1_n,
    input  wire        bus_cycle_active,
    input  wire        arb_request_pending,
    input  wire        system_reset_trigger_in_n,
    input  wire        alt_id_load,
    input  wire [7:0]  alt_id_data,
    input  wire        iack2_done,
    output reg         local_reset_out_ff,
    output reg         system_reset_trigger_out_ff,
    output reg         irq_level2_out_ff,
    output reg         sysfail_out_ff,
    output reg         cfg_image_en_ff,
    output reg         bus_timeout_ff,
    output reg         arb_timeout_ff,
    output wire        arb_mode_sel,
    output wire        system_controller_flag,
    output wire        isolation_mode,
    output wire [7:0]  user_address_modifier_codes_code_a,
    output wire [7:0]  user_address_modifier_codes_code_b
);

    // Two-flop synchronisers for every asynchronous input, in one vector.
    localparam NSYNC = 8;
    // Reset levels match each pin's idle state, so no false edge or early
    // acknowledge is seen in the first cycles after reset.
    localparam [NSYNC-1:0] SYNC_RST = 8'hfe;
    wire [NSYNC-1:0] async_in = {pci_rst_n, req64_n, own_bbsy_n, target_fifo_empty,
                                 slave_fifo_empty, irq_level1_n, system_reset_trigger_in_n, iack2_done};
    reg  [NSYNC-1:0] meta_ff;
    reg  [NSYNC-1:0] sync_ff;
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (reset) begin
                    meta_ff[gi] <= SYNC_RST[gi];
                    sync_ff[gi] <= SYNC_RST[gi];
                end else if (clk_en) begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate
    wire s_pci_rst_n = sync_ff[7];
    wire s_req64_n   = sync_ff[6];
    wire s_bbsy_n    = sync_ff[5];
    wire s_target_post_fifo_empty      = sync_ff[4];
    wire s_slave_post_fifo_empty      = sync_ff[3];
    wire s_irq1_n    = sync_ff[2];
    wire s_sysrst_n  = sync_ff[1];
    wire s_iack2     = sync_ff[0];

    // Bus-timeout code to number of 4 us ticks; zero means disabled.
    function [8:0] bto_ticks;
        input [3:0] code;
        begin
            case (code)
                4'h1:    bto_ticks = 9'h004;
                4'h2:    bto_ticks = 9'h008;
                4'h3:    bto_ticks = 9'h010;
                4'h4:    bto_ticks = 9'h020;
                4'h5:    bto_ticks = 9'h040;
                4'h6:    bto_ticks = 9'h080;
                4'h7:    bto_ticks = 9'h100;
                default: bto_ticks = 9'h000;
            endcase
        end
    endfunction

    // Arbitration-timeout code to ticks; reserved codes disable the timer.
    function [8:0] arbto_ticks;
        input [1:0] code;
        begin
            case (code)
                2'h1:    arbto_ticks = 9'h004;
                2'h2:    arbto_ticks = 9'h040;
                default: arbto_ticks = 9'h000;
            endcase
        end
    endfunction

    // Control fields.
    reg [3:0] bus_timeout_sel_ff;
    reg       arb_mode_sel_ff;
    reg [1:0] arb_timeout_sel_ff;
    reg       isolation_mode_ff;
    reg       global_isolation_enable_ff;
    reg       unused_legacy_bit_ff;
    reg       system_controller_flag_ff;
    reg [3:0] uam_a_ff;
    reg [3:0] uam_b_ff;
    reg       straps_taken_ff;

    wire wr_ctl = clk_en & reg_wr & (reg_addr == `VMC_OFF_CTL);
    wire wr_uam = clk_en & reg_wr & (reg_addr == `VMC_OFF_UAM);

    // The trigger bits are decoded as write pulses only; nothing stores them.
    // Pulse-only triggers
    wire pulse_local_reset_out   = wr_ctl & reg_wdata[`VMC_LOCAL_RESET_OUT_BIT] & ~wr_from_pci;
    wire pulse_brst   = wr_ctl & reg_wdata[`VMC_BRST_BIT] & wr_from_pci;
    wire pulse_sysrst = wr_ctl & reg_wdata[`VMC_SYSRST_BIT];
    wire pulse_auto   = wr_ctl & reg_wdata[`VMC_AUTOID_BIT];

    // Level-1 interrupt falling edge, taken from the synchronised copy.
    reg  irq1_prev_ff;
    wire irq1_assert = irq1_prev_ff & ~s_irq1_n;

    // Writable control fields. Strap values are caught on the first enabled
    // cycle after reset release so that the reset itself only loads constants.
    always @(posedge clk) begin
        if (reset) begin
            bus_timeout_sel_ff         <= `VMC_BTO_RST;
            arb_mode_sel_ff            <= 1'b0;
            arb_timeout_sel_ff         <= `VMC_ARBTO_RST;
            isolation_mode_ff          <= 1'b0;
            global_isolation_enable_ff <= 1'b0;
            unused_legacy_bit_ff       <= 1'b1;
            system_controller_flag_ff  <= 1'b0;
            uam_a_ff                   <= `VMC_UAM_RST;
            uam_b_ff                   <= `VMC_UAM_RST;
            straps_taken_ff            <= 1'b0;
            irq1_prev_ff               <= 1'b1;
        end else if (clk_en) begin
            irq1_prev_ff <= s_irq1_n;
            if (!straps_taken_ff) begin
                straps_taken_ff           <= 1'b1;
                isolation_mode_ff         <= strap_isolation;
                system_controller_flag_ff <= strap_system_controller_flag;
            end else if (wr_ctl) begin
                bus_timeout_sel_ff <= reg_wdata[`VMC_BTO_LSB +: 4];
                arb_mode_sel_ff    <= reg_wdata[`VMC_ARB_MODE_BIT];
                arb_timeout_sel_ff <= reg_wdata[`VMC_ARBTO_LSB +: 2];
                global_isolation_enable_ff <= reg_wdata[`VMC_GISO_BIT];
                unused_legacy_bit_ff <= reg_wdata[`VMC_LEGACY_BIT];
                system_controller_flag_ff <= reg_wdata[`VMC_SYSTEM_CONTROLLER_FLAG_BIT];
                isolation_mode_ff <= reg_wdata[`VMC_ISO_BIT];
            end
            // The initiator wins over a software clear in the same cycle.
            // Global isolation initiator
            if (straps_taken_ff && global_isolation_enable_ff && irq1_assert) begin
                isolation_mode_ff <= 1'b1;
            end
            if (wr_uam) begin
                uam_a_ff <= reg_wdata[`VMC_UAM_A_LSB +: 4];
                uam_b_ff <= reg_wdata[`VMC_UAM_B_LSB +: 4];
            end
        end
    end

    // Reset outputs are stretched pulses; the system reset bit leaves this
    // block's own state untouched, it only drives the pin.
    reg [7:0] local_reset_out_cnt_ff;
    reg [7:0] brst_cnt_ff;
    always @(posedge clk) begin
        if (reset) begin
            local_reset_out_cnt_ff        <= 8'h00;
            brst_cnt_ff        <= 8'h00;
            local_reset_out_ff <= 1'b0;
            system_reset_trigger_out_ff    <= 1'b0;
        end else if (clk_en) begin
            if (pulse_local_reset_out)
                local_reset_out_cnt_ff <= `VMC_PULSE_CYC;
            else if (local_reset_out_cnt_ff != 8'h00)
                local_reset_out_cnt_ff <= local_reset_out_cnt_ff - 8'h01;
            if (pulse_brst || pulse_sysrst)
                brst_cnt_ff <= `VMC_PULSE_CYC;
            else if (brst_cnt_ff != 8'h00)
                brst_cnt_ff <= brst_cnt_ff - 8'h01;
            local_reset_out_ff <= pulse_local_reset_out | (local_reset_out_cnt_ff > 8'h01);
            system_reset_trigger_out_ff    <= pulse_brst | pulse_sysrst | (brst_cnt_ff > 8'h01);
        end
    end

    // Auto-ID sequencer: raise level-2 interrupt, wait for its acknowledge,
    // then drop sysfail and open the configuration image.
    localparam AID_IDLE = 2'h0;
    localparam AID_IRQ  = 2'h1;
    localparam AID_DONE = 2'h2;
    reg [1:0] aid_state_ff;
    reg       aid_strap_done_ff;
    always @(posedge clk) begin
        if (reset) begin
            aid_state_ff      <= AID_IDLE;
            aid_strap_done_ff <= 1'b0;
            irq_level2_out_ff <= 1'b0;
            sysfail_out_ff    <= 1'b0;
            cfg_image_en_ff   <= 1'b1;
        end else if (clk_en) begin
            aid_strap_done_ff <= 1'b1;
            case (aid_state_ff)
                AID_IDLE: begin
                    if (pulse_auto || (!aid_strap_done_ff && strap_auto_id)) begin
                        aid_state_ff      <= AID_IRQ;
                        irq_level2_out_ff <= 1'b1;
                        sysfail_out_ff    <= 1'b1;
                        cfg_image_en_ff   <= 1'b0;
                    end
                end
                AID_IRQ: begin
                    if (s_iack2) begin
                        aid_state_ff      <= AID_DONE;
                        irq_level2_out_ff <= 1'b0;
                        sysfail_out_ff    <= 1'b0;
                        cfg_image_en_ff   <= 1'b1;
                    end
                end
                AID_DONE: begin
                    aid_state_ff <= AID_IDLE;
                end
                default: begin
                    aid_state_ff <= AID_IDLE;
                end
            endcase
        end
    end

    // Shared 4 us prescaler; up to one tick of early expiry is accepted.
    reg [7:0] tick_cnt_ff;
    wire      tick = (tick_cnt_ff == 8'h00);
    reg [8:0] bto_cnt_ff;
    reg [8:0] arb_cnt_ff;
    wire [8:0] bto_lim = bto_ticks(bus_timeout_sel_ff);
    wire [8:0] arb_lim = arbto_ticks(arb_timeout_sel_ff);
    always @(posedge clk) begin
        if (reset) begin
            tick_cnt_ff    <= 8'h00;
            bto_cnt_ff     <= 9'h000;
            arb_cnt_ff     <= 9'h000;
            bus_timeout_ff <= 1'b0;
            arb_timeout_ff <= 1'b0;
        end else if (clk_en) begin
            tick_cnt_ff <= tick ? (`VMC_TICK_CYC - 8'h01) : (tick_cnt_ff - 8'h01);
            if (!bus_cycle_active || bto_lim == 9'h000 || !system_controller_flag_ff)
                bto_cnt_ff <= 9'h000;
            else if (tick && bto_cnt_ff != bto_lim)
                bto_cnt_ff <= bto_cnt_ff + 9'h001;
            bus_timeout_ff <= (bto_lim != 9'h000) && (bto_cnt_ff == bto_lim) &&
                              bus_cycle_active && system_controller_flag_ff;
            if (!arb_request_pending || arb_lim == 9'h000 || !system_controller_flag_ff)
                arb_cnt_ff <= 9'h000;
            else if (tick && arb_cnt_ff != arb_lim)
                arb_cnt_ff <= arb_cnt_ff + 9'h001;
            arb_timeout_ff <= (arb_lim != 9'h000) && (arb_cnt_ff == arb_lim) &&
                              arb_request_pending && system_controller_flag_ff;
        end
    end

    // Status captured from the outside world.
    reg       pci_width_status_ff;
    reg       pci_rst_prev_ff;
    reg       alt_auto_id_enable_ff;
    reg       alt_auto_id_done_ff;
    reg [7:0] alt_auto_id_value_ff;
    always @(posedge clk) begin
        if (reset) begin
            pci_width_status_ff   <= 1'b0;
            pci_rst_prev_ff       <= 1'b1;
            alt_auto_id_enable_ff <= 1'b0;
            alt_auto_id_done_ff   <= 1'b0;
        end else if (clk_en) begin
            pci_rst_prev_ff <= s_pci_rst_n;
            if (s_pci_rst_n && !pci_rst_prev_ff)
                pci_width_status_ff <= ~s_req64_n;
            if (!straps_taken_ff)
                alt_auto_id_enable_ff <= strap_alt_auto_id;
            if (alt_id_load && alt_auto_id_enable_ff)
                alt_auto_id_done_ff <= 1'b1;
        end
    end

    // The alternate ID survives ordinary resets; only a backplane system reset
    // (system_reset_trigger_in_n low) clears it, so it is kept off the block reset.
    always @(posedge clk) begin
        if (clk_en) begin
            if (!s_sysrst_n)
                alt_auto_id_value_ff <= 8'h00;
            else if (alt_id_load && alt_auto_id_enable_ff)
                alt_auto_id_value_ff <= alt_id_data;
        end
    end

    // Read mux; reset trigger bits and reserved bits read as zero, the auto-ID bit reads as sequencer busy.
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (reg_addr)
            `VMC_OFF_CTL: begin
                nxt_rdata[`VMC_BTO_LSB +: 4]    = bus_timeout_sel_ff;
                nxt_rdata[`VMC_ARB_MODE_BIT]    = arb_mode_sel_ff;
                nxt_rdata[`VMC_ARBTO_LSB +: 2]  = arb_timeout_sel_ff;
                nxt_rdata[`VMC_ISO_BIT]         = isolation_mode_ff;
                nxt_rdata[`VMC_GISO_BIT]        = global_isolation_enable_ff;
                nxt_rdata[`VMC_LEGACY_BIT]      = unused_legacy_bit_ff;
                nxt_rdata[`VMC_SYSTEM_CONTROLLER_FLAG_BIT]      = system_controller_flag_ff;
                nxt_rdata[`VMC_AUTOID_BIT]      = (aid_state_ff == AID_IRQ);
            end
            `VMC_OFF_STAT: begin
                nxt_rdata[`VMC_PCIW_BIT]        = pci_width_status_ff;
                nxt_rdata[`VMC_ALTEN_BIT]       = alt_auto_id_enable_ff;
                nxt_rdata[`VMC_BBSY_BIT]        = s_bbsy_n;
                nxt_rdata[`VMC_ALTDONE_BIT]     = alt_auto_id_done_ff;
                nxt_rdata[`VMC_TARGET_POST_FIFO_EMPTY_BIT]        = s_target_post_fifo_empty;
                nxt_rdata[`VMC_SLAVE_POST_FIFO_EMPTY_BIT]        = s_slave_post_fifo_empty;
                nxt_rdata[`VMC_ALTID_LSB +: 8]  = alt_auto_id_value_ff;
            end
            `VMC_OFF_UAM: begin
                nxt_rdata[`VMC_UAM_A_LSB +: 6]  = {`VMC_UAM_PREFIX, uam_a_ff};
                nxt_rdata[`VMC_UAM_B_LSB +: 6]  = {`VMC_UAM_PREFIX, uam_b_ff};
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered one cycle after the read strobe.
    always @(posedge clk) begin
        if (reset)
            reg_rdata_ff <= 32'h0000_0000;
        else if (clk_en && reg_rd)
            reg_rdata_ff <= nxt_rdata;
    end

    assign arb_mode_sel           = arb_mode_sel_ff;
    assign system_controller_flag = system_controller_flag_ff;
    assign isolation_mode         = isolation_mode_ff;
    assign user_address_modifier_codes_code_a         = {`VMC_UAM_PREFIX, uam_a_ff, 2'h0};
    assign user_address_modifier_codes_code_b         = {`VMC_UAM_PREFIX, uam_b_ff, 2'h0};

endmodule
`default_nettype wire

// [bench/vmc_misc_asserts.sv]
// Checker for the misc control group: register strobes against the
// reset pulses, auto-ID handshake and fixed fields. Assumes one clock.
`timescale 1ns/10ps
`default_nettype none
`include "vmc_defines.vh"
module vmc_misc_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic        wr_from_pci,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic        iack2_done,
    input wire logic        local_reset_out_ff,
    input wire logic        system_reset_trigger_out_ff,
    input wire logic        irq_level2_out_ff,
    input wire logic        sysfail_out_ff,
    input wire logic        cfg_image_en_ff,
    input wire logic [7:0]  user_address_modifier_codes_code_a,
    input wire logic [7:0]  user_address_modifier_codes_code_b
);
    // A control write that the design takes on this edge.
    wire wr_ctl = clk_en && reg_wr && (reg_addr == `VMC_OFF_CTL);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_local_reset_out_take: assert property (
        wr_ctl && reg_wdata[23] && !wr_from_pci |=> local_reset_out_ff) else $error("no local_reset_out");
    a_local_reset_out_refuse: assert property (
        wr_ctl && reg_wdata[23] && wr_from_pci && !local_reset_out_ff |=> !local_reset_out_ff)
        else $error("local_reset_out from pci");
    a_brst_take: assert property (
        wr_ctl && reg_wdata[22] && wr_from_pci |=> system_reset_trigger_out_ff) else $error("no brst");
    a_pulse_len: assert property (
        $rose(system_reset_trigger_out_ff) |-> system_reset_trigger_out_ff[*8] ##1 system_reset_trigger_out_ff[*8] ##1 !system_reset_trigger_out_ff)
        else $error("pulse length");
    a_rd_selfclr: assert property (
        clk_en && reg_rd && reg_addr == `VMC_OFF_CTL |=> reg_rdata_ff[23:22] == 2'h0)
        else $error("reset bits read");
    a_uam_fixed: assert property (
        user_address_modifier_codes_code_a[7:6] == 2'h1 && user_address_modifier_codes_code_b[7:6] == 2'h1 && user_address_modifier_codes_code_a[1:0] == 2'h0)
        else $error("am prefix");
    a_autoid_go: assert property (
        wr_ctl && reg_wdata[16] |=> irq_level2_out_ff && sysfail_out_ff && !cfg_image_en_ff)
        else $error("autoid start");
    a_autoid_end: assert property (
        $rose(iack2_done) && irq_level2_out_ff |-> ##[1:4]
        (!irq_level2_out_ff && !sysfail_out_ff && cfg_image_en_ff)) else $error("autoid end");
endmodule
bind vmc_misc_regs vmc_misc_asserts u_chk (.clk(clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .wr_from_pci(wr_from_pci), .reg_rdata_ff(reg_rdata_ff), .iack2_done(iack2_done),
    .local_reset_out_ff(local_reset_out_ff), .system_reset_trigger_out_ff(system_reset_trigger_out_ff),
    .irq_level2_out_ff(irq_level2_out_ff), .sysfail_out_ff(sysfail_out_ff),
    .cfg_image_en_ff(cfg_image_en_ff), .user_address_modifier_codes_code_a(user_address_modifier_codes_code_a),
    .user_address_modifier_codes_code_b(user_address_modifier_codes_code_b));
`default_nettype wire

// [bench/vmc_bp_host.sv]
// Backplane interrupt handler model that acknowledges the level-2 request.
// Assumes it is clocked with the block and sees its request output.
`timescale 1ns/10ps
`default_nettype none
module vmc_bp_host #(
    parameter integer ack_delay = 20
) (
    input  wire logic clk,
    input  wire logic irq_level2_out_ff,
    output var  logic iack2_done
);
    // acknowledge after delay
    // The ack is held four cycles so the block can synchronise it safely.
    initial begin
        iack2_done = 1'h0;
        forever begin
            @(negedge clk);
            if (irq_level2_out_ff === 1'h1) begin
                repeat (ack_delay) @(negedge clk);
                iack2_done = 1'h1;
                repeat (4) @(negedge clk);
                iack2_done = 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/test_vme_pci_bridge_misc_control.sv]
// Self-checking bench for the misc control group: register table, pulses,
// auto-ID, isolation, status, timers and clock enable. Straps are held fixed.
`timescale 1ns/10ps
`default_nettype none
`include "vmc_defines.vh"
module test_vme_pci_bridge_misc_control;
    typedef struct {logic [11:0] a; logic [31:0] d; logic p; logic [31:0] m, e;} vmc_row_t;
    logic        clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, wr_from_pci = 1'h0;
    logic        pci_rst_n = 1'h0, req64_n = 1'h0, own_bbsy_n = 1'h1, t_empty = 1'h1;
    logic        s_empty = 1'h1, irq1_n = 1'h1, bus_act = 1'h0, arb_req = 1'h0;
    logic        sysrst_n = 1'h1, alt_load = 1'h0, iack2_done;
    logic        clk_en = 1'h1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, v;
    logic [7:0]  alt_data = 8'h0;
    wire  [31:0] rdata;
    wire         local_reset_out, srst, irq2, sfail, cfg, bto, arbto, iso;
    wire         am_sel, sc_flag;
    wire  [7:0]  uam_a, uam_b;
    integer      n_fail = 0, n_tests = 0, i, n;
    vmc_row_t    rows [8];
    vmc_misc_regs dut (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .wr_from_pci(wr_from_pci),
        .reg_rdata_ff(rdata), .strap_isolation(1'h0), .strap_system_controller_flag(1'h1),
        .strap_auto_id(1'h0), .strap_alt_auto_id(1'h1), .pci_rst_n(pci_rst_n),
        .req64_n(req64_n), .own_bbsy_n(own_bbsy_n), .target_fifo_empty(t_empty),
        .slave_fifo_empty(s_empty), .irq_level1_n(irq1_n), .bus_cycle_active(bus_act),
        .arb_request_pending(arb_req), .system_reset_trigger_in_n(sysrst_n), .alt_id_load(alt_load),
        .alt_id_data(alt_data), .iack2_done(iack2_done), .local_reset_out_ff(local_reset_out),
        .system_reset_trigger_out_ff(srst), .irq_level2_out_ff(irq2), .sysfail_out_ff(sfail),
        .cfg_image_en_ff(cfg), .bus_timeout_ff(bto), .arb_timeout_ff(arbto),
        .arb_mode_sel(am_sel), .system_controller_flag(sc_flag), .isolation_mode(iso),
        .user_address_modifier_codes_code_a(uam_a), .user_address_modifier_codes_code_b(uam_b));
    vmc_bp_host #(.ack_delay(20)) u_host (.clk(clk), .irq_level2_out_ff(irq2),
        .iack2_done(iack2_done));
    // Free-running 50 MHz clock.
    always #10 clk = ~clk;
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    // Strobes are one cycle wide, driven between rising edges.
    task wr(input [11:0] a, input [31:0] d, input p);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            wr_from_pci = p;
            reg_wr = 1'h1;
            @(negedge clk);
            reg_wr = 1'h0;
        end
    endtask
    // Read data is registered, so it is taken one cycle after the strobe.
    task rd(input [11:0] a, output [31:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_rd = 1'h1;
            @(negedge clk);
            reg_rd = 1'h0;
            @(negedge clk);
            d = rdata;
        end
    endtask
    task pulse(input [31:0] d, input p, input s);
        integer k;
        begin
            wr(`VMC_OFF_CTL, d, p);
            k = 0;
            while ((s ? srst : local_reset_out) === 1'h1 && k < 40) begin
                @(negedge clk);
                k = k + 1;
            end
            chk(k, 32'h10);
        end
    endtask
    // A limit on the wait keeps a dead timer from hanging the run.
    task tmr(input [31:0] d, input s, input integer lo, input integer hi);
        integer k;
        begin
            wr(`VMC_OFF_CTL, d, 1'h0);
            if (s) arb_req = 1'h1;
            else bus_act = 1'h1;
            k = 0;
            while ((s ? arbto : bto) !== 1'h1 && k < 1200) begin
                @(negedge clk);
                k = k + 1;
            end
            chk(k >= lo && k <= hi, 32'h1);
            bus_act = 1'h0;
            arb_req = 1'h0;
            repeat (4) @(negedge clk);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // Watchdog well beyond the expected run of a few thousand cycles.
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        rows = '{'{12'h404, 32'h761a0000, 1'h0, 32'hf7de0000, 32'h761a0000},
                 '{12'h404, 32'h00040000, 1'h1, 32'hf7de0000, 32'h00040000},
                 '{12'h404, 32'h00860000, 1'h1, 32'hf7de0000, 32'h00060000},
                 '{12'h404, 32'h00460000, 1'h0, 32'hf7de0000, 32'h00060000},
                 '{12'h40c, 32'hffffffff, 1'h0, 32'hfcfc0000, 32'h7c7c0000},
                 '{12'h40c, 32'h2ca40000, 1'h1, 32'hfcfc0000, 32'h6c640000},
                 '{12'h410, 32'hffffffff, 1'h0, 32'hffffffff, 32'h00000000},
                 '{12'h408, 32'hffffffff, 1'h0, 32'h484e0000, 32'h48460000}};
        repeat (5) @(negedge clk);
        reset = 1'h0;
        repeat (2) @(negedge clk);
        pci_rst_n = 1'h1;
        repeat (4) @(negedge clk);
        req64_n = 1'h1;
        for (i = 0; i < 8; i = i + 1) begin
            wr(rows[i].a, rows[i].d, rows[i].p);
            rd(rows[i].a, v);
            chk(v & rows[i].m, rows[i].e);
        end
        chk(irq2, 32'h0);
        pulse(32'h00860000, 1'h0, 1'h0);
        pulse(32'h00460000, 1'h1, 1'h1);
        pulse(32'h00064000, 1'h1, 1'h1);
        rd(`VMC_OFF_CTL, v);
        chk(v & 32'hf7de4000, 32'h00060000);
        wr(`VMC_OFF_CTL, 32'h00070000, 1'h1);
        chk({irq2, sfail, cfg}, 32'h6);
        rd(`VMC_OFF_CTL, v);
        chk(v[16], 32'h1);
        n = 0;
        while (cfg !== 1'h1 && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
        chk({irq2, sfail, cfg}, 32'h1);
        wr(`VMC_OFF_CTL, 32'h000e0000, 1'h0);
        irq1_n = 1'h0;
        repeat (5) @(negedge clk);
        chk(iso, 32'h1);
        irq1_n = 1'h1;
        wr(`VMC_OFF_CTL, 32'h00060000, 1'h0);
        irq1_n = 1'h0;
        repeat (5) @(negedge clk);
        chk(iso, 32'h0);
        irq1_n = 1'h1;
        own_bbsy_n = 1'h0;
        t_empty = 1'h0;
        s_empty = 1'h0;
        alt_data = 8'ha5;
        alt_load = 1'h1;
        @(negedge clk);
        alt_load = 1'h0;
        rd(`VMC_OFF_STAT, v);
        chk(v & 32'h004eff00, 32'h0008a500);
        own_bbsy_n = 1'h1;
        t_empty = 1'h1;
        s_empty = 1'h1;
        sysrst_n = 1'h0;
        repeat (4) @(negedge clk);
        sysrst_n = 1'h1;
        pci_rst_n = 1'h0;
        repeat (2) @(negedge clk);
        pci_rst_n = 1'h1;
        repeat (4) @(negedge clk);
        rd(`VMC_OFF_STAT, v);
        chk(v & 32'h4006ff00, 32'h00060000);
        tmr(32'h10060000, 1'h0, 600, 802);
        tmr(32'h01060000, 1'h1, 400, 802);
        reset = 1'h1;
        repeat (5) @(negedge clk);
        reset = 1'h0;
        repeat (3) @(negedge clk);
        rd(`VMC_OFF_CTL, v);
        chk(v & 32'hf7df0000, 32'h31060000);
        rd(`VMC_OFF_UAM, v);
        chk(v & 32'hfcfc0000, 32'h40400000);
        // Field copies out of reset: round-robin, strapped controller, codes 0x40.
        chk({am_sel, sc_flag, uam_a, uam_b}, 32'h00014040);
        // A write while the clock enable is low must leave the codes untouched.
        clk_en = 1'h0;
        wr(`VMC_OFF_UAM, 32'hffffffff, 1'h0);
        clk_en = 1'h1;
        rd(`VMC_OFF_UAM, v);
        chk(v & 32'hfcfc0000, 32'h40400000);
        end_of_test;
    end
endmodule
`default_nettype wire
